/* rtl/sar_pkg.sv */
// Shared constants for both ends of the serial converter link.
package sar_pkg;

    // ********************************************************
    // Word sizes
    // ********************************************************
    localparam int unsigned ADDR_W     = 4;
    localparam int unsigned RES_W      = 10;
    localparam int unsigned NUM_CH     = 11;
    localparam int unsigned FIFO_DEPTH = 4;

    // ********************************************************
    // Timing
    // ********************************************************
    localparam int unsigned CLK_PERIOD_NS = 40;
    localparam int unsigned CONV_TIME_NS  = 44000;
    // Longest time, so the cycle count rounds down.
    localparam int unsigned CONV_CYC      = CONV_TIME_NS / CLK_PERIOD_NS;
    localparam int unsigned STEP_CYC      = CONV_CYC / RES_W;
    localparam int unsigned SCLK_HALF_CYC = 4;

    // ********************************************************
    // Synchroniser lanes and reset values
    // ********************************************************
    localparam int unsigned SYNC_W   = 3;
    localparam int unsigned LANE_CS  = 2;
    localparam int unsigned LANE_CLK = 1;
    localparam int unsigned LANE_DIN = 0;
    localparam logic [RES_W-1:0]  SAR_FIRST  = 10'h200;
    localparam logic [RES_W-1:0]  RESULT_RST = 10'h000;
    localparam logic [ADDR_W-1:0] ADDR_RST   = 4'h0;
    localparam logic              EOC_RST    = 1'b1;

endpackage

/* rtl/sar_link_if.sv */
// Serial link between the converter and its host.
`timescale 1ns/1ps
interface sar_link_if;
    logic cs_n;
    logic sclk;
    logic din;
    logic dout;
    logic eoc;

    modport adc (
        input  cs_n,
        input  sclk,
        input  din,
        output dout,
        output eoc
    );

    modport host (
        output cs_n,
        output sclk,
        output din,
        input  dout,
        input  eoc
    );
endinterface

/* rtl/sar_adc_dev.sv */
// Converter end: serial slave port plus successive approximation core.
//
// How it works
// - Select low starts address receive and result send.
// - Full address received starts a new conversion.
// - Previous result shifts out while address shifts in.
// - Internal timebase steps the approximation register.
// - Finished value held in result register until sent.
// - Conversion-done goes high when conversion finishes.
// - Host raises select before the next transaction.
// - Result MSB appears once select falls, MSB first.
// - Output advances one bit after each falling clock.
// - After ten bits the output stays low.
// - Address bits taken on rising clock, MSB first.
// - Data input ignored after the fourth address bit.
// - Host drives the shift clock for both registers.
// - Selected one of eleven inputs becomes ten bits.
// - Each conversion completes within 44 microseconds.
// - Keep bit if input exceeds trial, then halve.
// - Conversion-done goes low on tenth falling clock.
// - Host raises select after the result bits.
`timescale 1ns/1ps
module sar_adc_dev #(
    parameter int unsigned NUM_CH = sar_pkg::NUM_CH
) (
    // Clock and reset
    input  wire logic                           ref_clk,
    input  wire logic                           arst_n,
    // Serial link
    sar_link_if.adc                             link,
    // Sampled input levels, channel 0 in the low bits
    input  wire logic [NUM_CH*sar_pkg::RES_W-1:0] ain_level,
    // Status
    output logic      [sar_pkg::RES_W-1:0]      result,
    output logic                                busy
);
    import sar_pkg::*;

    // ********************************************************
    // Parameter check
    // ********************************************************
    // The address is four bits wide, so no more than sixteen inputs.
    if (NUM_CH < 1 || NUM_CH > (1 << ADDR_W)) begin : g_bad_ch
        $error("NUM_CH must lie between 1 and 16");
    end

    typedef enum logic {
        SAR_IDLE,
        SAR_RUN
    } sar_state_t;

    localparam int unsigned STEP_W = $clog2(STEP_CYC);
    localparam logic [STEP_W-1:0] STEP_LAST = STEP_W'(STEP_CYC - 1);
    localparam logic [2:0] ADDR_LAST = 3'(ADDR_W - 1);
    localparam logic [3:0] TX_LAST   = 4'(RES_W - 1);

    // ********************************************************
    // Pin synchronisers
    // ********************************************************
    logic [SYNC_W-1:0] pin_in;
    logic [SYNC_W-1:0] meta_ff;
    logic [SYNC_W-1:0] sync_ff;
    logic [SYNC_W-1:0] prev_ff;

    assign pin_in[LANE_CS]  = link.cs_n;
    assign pin_in[LANE_CLK] = link.sclk;
    assign pin_in[LANE_DIN] = link.din;

    // The shift clock is only sampled, never used as a clock.
    for (genvar i = 0; i < SYNC_W; i++) begin : g_sync
        always_ff @(posedge ref_clk or negedge arst_n) begin
            if (!arst_n) begin
                meta_ff[i] <= 1'b1;
                sync_ff[i] <= 1'b1;
                prev_ff[i] <= 1'b1;
            end else begin
                meta_ff[i] <= pin_in[i];
                sync_ff[i] <= meta_ff[i];
                prev_ff[i] <= sync_ff[i];
            end
        end
    end

    wire sel_on    = ~sync_ff[LANE_CS];
    wire sel_fall  = prev_ff[LANE_CS] & ~sync_ff[LANE_CS];
    wire sclk_rise = sel_on & ~prev_ff[LANE_CLK] & sync_ff[LANE_CLK];
    wire sclk_fall = sel_on & prev_ff[LANE_CLK] & ~sync_ff[LANE_CLK];
    wire din_s     = sync_ff[LANE_DIN];

    // ********************************************************
    // Address receiver
    // ********************************************************
    logic [ADDR_W-1:0] addr_ff;
    logic [2:0]        rx_cnt_ff;

    wire rx_open = rx_cnt_ff <= ADDR_LAST;
    wire rx_take = sclk_rise & rx_open;
    wire rx_done = rx_take & (rx_cnt_ff == ADDR_LAST);
    wire [ADDR_W-1:0] nxt_addr = {addr_ff[ADDR_W-2:0], din_s};

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            addr_ff   <= ADDR_RST;
            rx_cnt_ff <= 3'h0;
        end else if (sel_fall) begin
            rx_cnt_ff <= 3'h0;
        end else if (rx_take) begin
            addr_ff   <= nxt_addr;
            rx_cnt_ff <= rx_cnt_ff + 3'h1;
        end
    end

    // ********************************************************
    // Result transmitter
    // ********************************************************
    logic [RES_W-1:0] tx_sh_ff;
    logic [3:0]       tx_cnt_ff;
    logic             dout_ff;
    logic             eoc_ff;

    wire tx_tenth = sclk_fall & (tx_cnt_ff == TX_LAST);
    wire [RES_W-1:0] tx_next = {tx_sh_ff[RES_W-2:0], 1'b0};

    // Zeros fill from the bottom, so the line is low after bit ten.
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            tx_sh_ff  <= RESULT_RST;
            tx_cnt_ff <= 4'h0;
            dout_ff   <= 1'b0;
        end else if (sel_fall) begin
            tx_sh_ff  <= result;
            tx_cnt_ff <= 4'h0;
            dout_ff   <= result[RES_W-1];
        end else if (!sel_on) begin
            dout_ff   <= 1'b0;
        end else if (sclk_fall) begin
            tx_sh_ff  <= tx_next;
            dout_ff   <= tx_next[RES_W-1];
            if (tx_cnt_ff != 4'hF) begin
                tx_cnt_ff <= tx_cnt_ff + 4'h1;
            end
        end
    end

    // ********************************************************
    // Input selection
    // ********************************************************
    logic [RES_W-1:0] lvl [NUM_CH];

    for (genvar c = 0; c < NUM_CH; c++) begin : g_chan
        assign lvl[c] = ain_level[c*RES_W +: RES_W];
    end

    // An address beyond the last input converts as zero.
    wire              ch_ok  = 32'(nxt_addr) < NUM_CH;
    wire [RES_W-1:0]  ch_lvl = ch_ok ? lvl[nxt_addr] : RESULT_RST;

    // ********************************************************
    // Successive approximation core
    // ********************************************************
    sar_state_t       state_ff;
    logic [RES_W-1:0] hold_ff;
    logic [RES_W-1:0] sar_ff;
    logic [RES_W-1:0] wt_ff;
    logic [STEP_W-1:0] step_ff;
    logic [RES_W-1:0] result_ff;

    wire step_end = (state_ff == SAR_RUN) & (step_ff == STEP_LAST);
    wire keep     = hold_ff > sar_ff;
    wire [RES_W-1:0] nxt_sar = (keep ? sar_ff : (sar_ff & ~wt_ff))
                             | (wt_ff >> 1);
    wire conv_end = step_end & wt_ff[0];

    // A new address restarts the core even mid conversion.
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_ff <= SAR_IDLE;
            hold_ff  <= RESULT_RST;
            sar_ff   <= RESULT_RST;
            wt_ff    <= RESULT_RST;
            step_ff  <= '0;
        end else if (rx_done) begin
            state_ff <= SAR_RUN;
            hold_ff  <= ch_lvl;
            sar_ff   <= SAR_FIRST;
            wt_ff    <= SAR_FIRST;
            step_ff  <= '0;
        end else begin
            case (state_ff)
                SAR_IDLE: begin
                    step_ff <= '0;
                end
                SAR_RUN: begin
                    step_ff <= step_end ? '0 : step_ff + 1'b1;
                    if (step_end) begin
                        sar_ff <= nxt_sar;
                        wt_ff  <= wt_ff >> 1;
                    end
                    if (conv_end) begin
                        state_ff <= SAR_IDLE;
                    end
                end
                default: begin
                    state_ff <= SAR_IDLE;
                end
            endcase
        end
    end

    // ********************************************************
    // Result register and conversion-done flag
    // ********************************************************
    // The finishing conversion wins over the tenth clock edge.
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            result_ff <= RESULT_RST;
            eoc_ff    <= EOC_RST;
        end else if (conv_end) begin
            result_ff <= nxt_sar;
            eoc_ff    <= 1'b1;
        end else if (tx_tenth) begin
            eoc_ff    <= 1'b0;
        end
    end

    assign result    = result_ff;
    assign busy      = state_ff == SAR_RUN;
    assign link.dout = dout_ff;
    assign link.eoc  = eoc_ff;

endmodule

/* rtl/sar_host.sv */
// Host end: serial master with a result FIFO toward the user.
`timescale 1ns/1ps
module sar_fifo #(
    parameter int unsigned WIDTH = sar_pkg::RES_W,
    parameter int unsigned DEPTH = sar_pkg::FIFO_DEPTH
) (
    // Clock and reset
    input  wire logic             ref_clk,
    input  wire logic             arst_n,
    // Fill side
    input  wire logic             in_valid,
    output logic                  in_ready,
    input  wire logic [WIDTH-1:0] in_data,
    // Drain side
    output logic                  out_valid,
    input  wire logic             out_ready,
    output logic      [WIDTH-1:0] out_data
);
    // Pointers carry one extra bit to tell full from empty.
    if (DEPTH < 2 || (DEPTH & (DEPTH - 1)) != 0) begin : g_bad_depth
        $error("DEPTH must be a power of two of at least 2");
    end

    localparam int unsigned PW = $clog2(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [PW:0]      wr_ff;
    logic [PW:0]      rd_ff;

    wire full  = (wr_ff[PW] != rd_ff[PW]) & (wr_ff[PW-1:0] == rd_ff[PW-1:0]);
    wire empty = wr_ff == rd_ff;
    wire push  = in_valid & ~full;
    wire pop   = out_ready & ~empty;

    always_ff @(posedge ref_clk) begin
        if (push) begin
            mem[wr_ff[PW-1:0]] <= in_data;
        end
    end

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            wr_ff <= '0;
            rd_ff <= '0;
        end else begin
            wr_ff <= wr_ff + (PW+1)'(push);
            rd_ff <= rd_ff + (PW+1)'(pop);
        end
    end

    assign in_ready  = ~full;
    assign out_valid = ~empty;
    assign out_data  = mem[rd_ff[PW-1:0]];
endmodule

module sar_host (
    // Clock and reset
    input  wire logic                         ref_clk,
    input  wire logic                         arst_n,
    // Serial link
    sar_link_if.host                          link,
    // Conversion requests
    input  wire logic                         req_valid,
    output logic                              req_ready,
    input  wire logic [sar_pkg::ADDR_W-1:0]   req_ch,
    // Results of the previous conversion
    output logic                              res_valid,
    input  wire logic                         res_ready,
    output logic      [sar_pkg::RES_W-1:0]    res_data
);
    import sar_pkg::*;

    typedef enum logic [2:0] {
        H_IDLE, H_LEAD, H_HI, H_LO, H_TAIL, H_WLO, H_WHI
    } sar_hstate_t;

    localparam logic [2:0] HALF_LAST = 3'(SCLK_HALF_CYC - 1);
    localparam logic [3:0] BIT_LAST  = 4'(RES_W - 1);

    // ********************************************************
    // Input synchronisers
    // ********************************************************
    logic [1:0] meta_ff;
    logic [1:0] sync_ff;

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            meta_ff <= 2'h0;
            sync_ff <= 2'h0;
        end else begin
            meta_ff <= {link.eoc, link.dout};
            sync_ff <= meta_ff;
        end
    end

    wire eoc_s  = sync_ff[1];
    wire dout_s = sync_ff[0];

    // ********************************************************
    // Transaction sequencer
    // ********************************************************
    sar_hstate_t       state_ff;
    logic [2:0]        tmr_ff;
    logic [3:0]        bit_ff;
    logic [ADDR_W-1:0] addr_sh_ff;
    logic [RES_W-1:0]  rx_ff;
    logic              cs_n_ff;
    logic              sclk_ff;
    logic              din_ff;
    logic              ready_ff;
    logic              push_ff;
    logic              fifo_ready;

    wire half_end = tmr_ff == HALF_LAST;
    wire take     = req_valid & ready_ff & (state_ff == H_IDLE);
    wire [ADDR_W-1:0] nxt_addr_sh = {addr_sh_ff[ADDR_W-2:0], 1'b0};

    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            state_ff   <= H_IDLE;
            tmr_ff     <= 3'h0;
            bit_ff     <= 4'h0;
            addr_sh_ff <= ADDR_RST;
            rx_ff      <= RESULT_RST;
            cs_n_ff    <= 1'b1;
            sclk_ff    <= 1'b0;
            din_ff     <= 1'b0;
            ready_ff   <= 1'b0;
            push_ff    <= 1'b0;
        end else begin
            tmr_ff   <= (state_ff == H_IDLE || half_end) ? 3'h0
                                                        : tmr_ff + 3'h1;
            push_ff  <= 1'b0;
            ready_ff <= (state_ff == H_IDLE) & fifo_ready & eoc_s & ~take;
            case (state_ff)
                H_IDLE: begin
                    if (take) begin
                        cs_n_ff    <= 1'b0;
                        addr_sh_ff <= req_ch;
                        din_ff     <= req_ch[ADDR_W-1];
                        bit_ff     <= 4'h0;
                        state_ff   <= H_LEAD;
                    end
                end
                H_LEAD, H_LO: begin
                    if (half_end) begin
                        sclk_ff  <= 1'b1;
                        state_ff <= H_HI;
                    end
                end
                H_HI: begin
                    // Sampled late in the high phase to cover both
                    // synchroniser delays on the returning data.
                    if (half_end) begin
                        rx_ff      <= {rx_ff[RES_W-2:0], dout_s};
                        sclk_ff    <= 1'b0;
                        addr_sh_ff <= nxt_addr_sh;
                        din_ff     <= nxt_addr_sh[ADDR_W-1];
                        bit_ff     <= bit_ff + 4'h1;
                        state_ff   <= (bit_ff == BIT_LAST) ? H_TAIL : H_LO;
                    end
                end
                H_TAIL: begin
                    if (half_end) begin
                        cs_n_ff  <= 1'b1;
                        push_ff  <= 1'b1;
                        state_ff <= H_WLO;
                    end
                end
                H_WLO: begin
                    if (!eoc_s) begin
                        state_ff <= H_WHI;
                    end
                end
                H_WHI: begin
                    if (eoc_s) begin
                        state_ff <= H_IDLE;
                    end
                end
                default: begin
                    state_ff <= H_IDLE;
                end
            endcase
        end
    end

    // ********************************************************
    // Result buffer
    // ********************************************************
    // A request is taken only while the FIFO has room, so a stalled
    // reader holds the link idle instead of losing a result.
    sar_fifo #(
        .WIDTH (RES_W),
        .DEPTH (FIFO_DEPTH)
    ) u_fifo (
        .ref_clk   (ref_clk),
        .arst_n    (arst_n),
        .in_valid  (push_ff),
        .in_ready  (fifo_ready),
        .in_data   (rx_ff),
        .out_valid (res_valid),
        .out_ready (res_ready),
        .out_data  (res_data)
    );

    assign req_ready = ready_ff;
    assign link.cs_n = cs_n_ff;
    assign link.sclk = sclk_ff;
    assign link.din  = din_ff;

endmodule

/* tb/sar_link_monitor.sv */
// Checker for the serial link between host and converter.
`timescale 1ns/1ps
module sar_link_monitor (
    // Clock and reset
    input wire logic ref_clk,
    input wire logic arst_n,
    // Link signals
    input wire logic cs_n,
    input wire logic sclk,
    input wire logic din,
    input wire logic dout,
    input wire logic eoc
);
    // ********
    // Edge counters
    // ********
    logic        sclk_ff;
    logic        cs_ff;
    logic [3:0]  falls_ff;
    logic [2:0]  quiet_ff;
    logic [10:0] low_ff;
    wire         fall  = sclk_ff & ~sclk & ~cs_n;
    wire         tenth = fall & (falls_ff == 4'h9);
    wire         evt   = fall | (cs_ff ^ cs_n);
    wire         sat   = (quiet_ff == 3'h7);
    // The converter sees the pins through a synchroniser, so its answers
    // trail the pin changes by a few cycles; the bounds allow for that.
    always_ff @(posedge ref_clk or negedge arst_n) begin
        if (!arst_n) begin
            sclk_ff  <= 1'b0;
            cs_ff    <= 1'b1;
            falls_ff <= 4'h0;
            quiet_ff <= 3'h7;
            low_ff   <= 11'h000;
        end else begin
            sclk_ff  <= sclk;
            cs_ff    <= cs_n;
            falls_ff <= cs_n ? 4'h0 : falls_ff + {3'h0, fall};
            quiet_ff <= evt ? 3'h0 : quiet_ff + {2'h0, ~sat};
            low_ff   <= eoc ? 11'h000 : low_ff + 11'h001;
        end
    end
    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);
    // ********
    // Link properties
    // ********
    // The host holds one half period of clock-low lead after select falls.
    sel_setup_a: assert property ($fell(cs_n) |-> (!sclk) [*4])
        else $error("clock pulsed too soon after select fell");
    sclk_idle_a: assert property (cs_n |-> !sclk)
        else $error("clock moved while select was high");
    din_hold_a: assert property (sclk && !cs_n |-> $stable(din))
        else $error("address bit changed while clock was high");
    frame_len_a: assert property ($rose(cs_n) |-> falls_ff == 4'hA)
        else $error("select rose after a wrong number of clocks");
    eoc_drop_a: assert property (tenth |-> ##[1:5] !eoc)
        else $error("done stayed high after the tenth falling clock");
    eoc_time_a: assert property (low_ff <= 11'h44C)
        else $error("conversion took too long");
    eoc_rise_a: assert property ($rose(eoc) |-> low_ff >= 11'h384)
        else $error("done rose before the conversion could finish");
    dout_step_a: assert property ($changed(dout) |-> quiet_ff <= 3'h5)
        else $error("result line changed without a clock fall");
    tail_low_a: assert property (tenth |-> ##5 !dout)
        else $error("result line not low after ten bits");
endmodule

/* tb/serial_sar_adc_interface_tb.sv */
// Bench for both converter link ends plus a bench-driven converter.
`timescale 1ns/1ps
module serial_sar_adc_interface_tb;
    import sar_pkg::*;
    // ********
    // Signals and instances
    // ********
    logic                    ref_clk;
    logic                    arst_n;
    logic                    req_valid;
    logic                    req_ready;
    logic [ADDR_W-1:0]       req_ch;
    logic                    res_valid;
    logic                    res_ready;
    logic [RES_W-1:0]        res_data;
    logic [NUM_CH*RES_W-1:0] ain;
    logic [RES_W-1:0]        result;
    logic [RES_W-1:0]        result2;
    logic                    busy;
    logic                    busy2;
    logic [RES_W-1:0]        expq[$];
    int                      lst1[4] = '{0, 10, 5, 7};
    int                      lst2[4] = '{9, 2, 12, 0};
    int                      failures;
    int                      comparisons;
    sar_link_if lnk();
    sar_link_if lnk2();
    sar_adc_dev sar_adc_dev_i (.ref_clk(ref_clk), .arst_n(arst_n),
        .link(lnk.adc), .ain_level(ain), .result(result), .busy(busy));
    sar_adc_dev sar_adc_dev_i2 (.ref_clk(ref_clk), .arst_n(arst_n),
        .link(lnk2.adc), .ain_level(ain), .result(result2), .busy(busy2));
    sar_host sar_host_i (.ref_clk(ref_clk), .arst_n(arst_n), .link(lnk.host),
        .req_valid(req_valid), .req_ready(req_ready), .req_ch(req_ch),
        .res_valid(res_valid), .res_ready(res_ready), .res_data(res_data));
    sar_link_monitor sar_link_monitor_i (.ref_clk(ref_clk),
        .arst_n(arst_n), .cs_n(lnk.cs_n), .sclk(lnk.sclk), .din(lnk.din),
        .dout(lnk.dout), .eoc(lnk.eoc));
    // ********
    // Tasks
    // ********
    task automatic tick(input int n);
        repeat (n) @(posedge ref_clk);
        #1;
    endtask
    task automatic chk_bit(input string what, input logic e, input logic g);
        comparisons++;
        if (g !== e) begin
            failures++;
            $display("mismatch %s expected %b seen %b", what, e, g);
        end
    endtask
    task automatic chk_word(input string what, input logic [RES_W-1:0] e,
                            input logic [RES_W-1:0] g);
        comparisons++;
        if (g !== e) begin
            failures++;
            $display("mismatch %s expected %h seen %h", what, e, g);
        end
    endtask
    function automatic logic [RES_W-1:0] conv(input int c);
        logic [RES_W-1:0] r;
        logic [RES_W-1:0] t;
        r = 10'h000;
        // An address past the last input converts as zero.
        if (c >= NUM_CH) begin
            return r;
        end
        for (int b = RES_W - 1; b >= 0; b--) begin
            t = r | (10'h001 << b);
            if (ain[c*RES_W +: RES_W] > t) begin
                r = t;
            end
        end
        return r;
    endfunction
    task automatic request(input int c);
        int n;
        n = 0;
        while (req_ready !== 1'b1 && n < 2000) begin
            tick(1);
            n++;
        end
        chk_bit("req_ready", 1'b1, req_ready);
        req_valid = 1'b1;
        req_ch = 4'(c);
        tick(1);
        req_valid = 1'b0;
        expq.push_back(conv(c));
        tick(2);
    endtask
    task automatic pop;
        int n;
        n = 0;
        while (res_valid !== 1'b1 && n < 2000) begin
            tick(1);
            n++;
        end
        chk_word("res_data", expq.pop_front(), res_data);
        res_ready = 1'b1;
        tick(1);
        res_ready = 1'b0;
        tick(1);
    endtask
    // Two clocks beyond the tenth show the low tail, and the address line
    // toggles after the fourth bit, which must go unheard.
    task automatic xfer(input int c, input logic [RES_W-1:0] e);
        logic [11:0] bits;
        int          n;
        lnk2.cs_n = 1'b0;
        tick(8);
        chk_bit("first dout", e[RES_W-1], lnk2.dout);
        for (int k = 0; k < 12; k++) begin
            lnk2.din = (k < ADDR_W) ? c[ADDR_W-1-k] : k[0];
            tick(4);
            lnk2.sclk = 1'b1;
            tick(4);
            bits[11-k] = lnk2.dout;
            lnk2.sclk = 1'b0;
        end
        tick(4);
        chk_bit("eoc after tenth fall", 1'b0, lnk2.eoc);
        chk_word("shifted result", e, bits[11:2]);
        chk_word("tail bits", 10'h000, {8'h00, bits[1:0]});
        lnk2.cs_n = 1'b1;
        tick(2);
        chk_bit("busy", 1'b1, busy2);
        n = 0;
        while (lnk2.eoc !== 1'b1 && n < 1200) begin
            tick(1);
            n++;
        end
        chk_bit("eoc done", 1'b1, lnk2.eoc);
        chk_word("result", conv(c), result2);
        chk_bit("busy done", 1'b0, busy2);
    endtask
    task automatic give_verdict;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // ********
    // Clock, watchdog and sequence
    // ********
    initial begin
        ref_clk = 1'b0;
        forever #20 ref_clk = ~ref_clk;
    end
    // About 9600 cycles are needed; the margin covers slow handshakes.
    initial begin
        repeat (20000) @(posedge ref_clk);
        failures++;
        give_verdict();
    end
    initial begin
        logic [RES_W-1:0] prev;
        arst_n = 1'b0;
        req_valid = 1'b0;
        req_ch = 4'h0;
        res_ready = 1'b0;
        lnk2.cs_n = 1'b1;
        lnk2.sclk = 1'b0;
        lnk2.din = 1'b0;
        for (int c = 0; c < NUM_CH; c++) begin
            ain[c*RES_W +: RES_W] = 10'(c * 10'h05D + 10'h011);
        end
        ain[RES_W-1:0] = 10'h3FF;
        ain[10*RES_W +: RES_W] = 10'h000;
        tick(4);
        arst_n = 1'b1;
        tick(1);
        chk_bit("eoc reset", EOC_RST, lnk2.eoc);
        prev = RESULT_RST;
        foreach (lst2[i]) begin
            xfer(lst2[i], prev);
            prev = conv(lst2[i]);
        end
        expq.push_back(RESULT_RST);
        foreach (lst1[i]) begin
            request(lst1[i]);
        end
        tick(1500);
        chk_bit("full refuses", 1'b0, req_ready);
        chk_word("held result", conv(7), result);
        chk_bit("idle busy", 1'b0, busy);
        ain[7*RES_W +: RES_W] = 10'h123;
        repeat (4) begin
            pop();
        end
        chk_bit("drained", 1'b0, res_valid);
        request(3);
        pop();
        give_verdict();
    end
endmodule
